// ### design/video_sync_pkg.sv
package video_sync_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 6;
	localparam int PIX_W  = 7;
	localparam int COPY_W = 9;
	localparam int WID_W  = 4;

	// write map
	localparam logic [ADDR_W-1:0] WR_VSYNC_CTRL  = 6'h00;
	localparam logic [ADDR_W-1:0] WR_VERTICAL_BLANK_INPUT_CONTROL_CTRL = 6'h01;
	localparam logic [ADDR_W-1:0] WR_LINE_WAIT   = 6'h02;
	localparam logic [ADDR_W-1:0] WR_HCNT_RESET  = 6'h03;
	localparam logic [ADDR_W-1:0] WR_OBJ0_NS     = 6'h04;
	localparam logic [ADDR_W-1:0] WR_OBJ1_NS     = 6'h05;
	localparam logic [ADDR_W-1:0] WR_PF_CTRL     = 6'h0a;
	localparam logic [ADDR_W-1:0] WR_PF_FIRST    = 6'h0d;
	localparam logic [ADDR_W-1:0] WR_PF_SECOND   = 6'h0e;
	localparam logic [ADDR_W-1:0] WR_PF_THIRD    = 6'h0f;
	// read map: input ports 0..5, read on data line 7
	localparam logic [ADDR_W-1:0] RD_INPUT_LAST  = 6'h05;
	localparam int RD_BIT = 7;
	localparam int NUM_INPUTS = 6;
	localparam int NUM_DUMPED = 4;

	// field positions
	localparam int SYNC_BIT    = 1;
	localparam int VBL_BIT     = 1;
	localparam int LATCH_BIT   = 6;
	localparam int DUMP_BIT    = 7;
	localparam int REFLECT_BIT = 0;
	localparam int SCORE_BIT   = 1;
	localparam int PRIO_BIT    = 2;
	localparam int SIZE_LSB    = 4;
	localparam int SIZE_MSB    = 5;
	localparam int COPY_LSB    = 0;
	localparam int COPY_MSB    = 2;

	// pixel word layout
	localparam int PIX_PF   = 0;
	localparam int PIX_SEL  = 1;
	localparam int PIX_PRIO = 3;
	localparam int PIX_HBL  = 4;
	localparam int PIX_VBL  = 5;
	localparam int PIX_VSY  = 6;

	// line timing in colour clocks
	localparam logic [7:0] LINE_CLOCKS    = 8'he4;
	localparam logic [7:0] HBLANK_CLOCKS  = 8'h44;
	localparam logic [7:0] VISIBLE_CLOCKS = 8'ha0;
	localparam logic [7:0] HALF_CLOCKS    = 8'h50;
	localparam int PF_BIT_SHIFT = 2;
	localparam logic [4:0] PF_HALF_BITS = 5'h14;
	localparam int GRID_CLOCKS = 8;

	// colour clock enable from the system clock
	localparam int SYS_CLK_KHZ   = 250000;
	localparam int COLOR_CLK_KHZ = 3580;
	localparam int COLOR_DIV     = SYS_CLK_KHZ / COLOR_CLK_KHZ;

	typedef enum logic [1:0] {SEL_PF, SEL_P0, SEL_P1} color_sel_type;
endpackage

// ### design/video_sync_playfield_control.sv
`timescale 1ns/1ps
module video_sync_playfield_control (
	input  wire logic                               i_clk,
	input  wire logic                               i_sys_rst,
	input  wire logic                               i_wr_en,
	input  wire logic [video_sync_pkg::ADDR_W-1:0]  i_wr_addr,
	input  wire logic [video_sync_pkg::DATA_W-1:0]  i_wr_data,
	input  wire logic                               i_rd_en,
	input  wire logic [video_sync_pkg::ADDR_W-1:0]  i_rd_addr,
	output logic      [video_sync_pkg::DATA_W-1:0]  o_rd_data,
	output logic                                    o_cpu_ready,
	input  wire logic [video_sync_pkg::NUM_DUMPED-1:0] i_dump_pin,
	output logic      [video_sync_pkg::NUM_DUMPED-1:0] o_dump_out,
	output logic      [video_sync_pkg::NUM_DUMPED-1:0] o_dump_oe,
	input  wire logic [1:0]                         i_latch_pin,
	output logic                                    o_vsync,
	output logic                                    o_vertical_blank_input_control,
	output logic                                    o_hblank,
	output logic                                    o_pix_valid,
	input  wire logic                               i_pix_ready,
	output logic      [video_sync_pkg::PIX_W-1:0]   o_pix_data,
	output logic      [video_sync_pkg::WID_W-1:0]   o_ball_width,
	output logic      [video_sync_pkg::WID_W-1:0]   o_missile0_width,
	output logic      [video_sync_pkg::WID_W-1:0]   o_missile1_width,
	output logic      [video_sync_pkg::COPY_W-1:0]  o_obj0_copies,
	output logic      [video_sync_pkg::COPY_W-1:0]  o_obj1_copies,
	output logic      [1:0]                         o_obj0_scale,
	output logic      [1:0]                         o_obj1_scale
);
	import video_sync_pkg::*;

	// width code 00/01/10/11 -> 1/2/4/8 colour clocks
	function automatic logic [WID_W-1:0] size_width(input logic [1:0] code);
		size_width = WID_W'(1) << code;
	endfunction

	// copy start squares, each square GRID_CLOCKS wide
	function automatic logic [COPY_W-1:0] copy_map(input logic [2:0] code);
		logic [COPY_W-1:0] m;
		m = COPY_W'(1);
		unique case (code)
			3'h1: m[2] = 1'b1;
			3'h2: m[4] = 1'b1;
			3'h3: m = m | COPY_W'(9'h014);
			3'h4: m[8] = 1'b1;
			3'h6: m = m | COPY_W'(9'h110);
			3'h0, 3'h5, 3'h7: m = COPY_W'(1);
		endcase
		copy_map = m;
	endfunction

	// scale: 0 normal, 1 double, 2 quad
	function automatic logic [1:0] copy_scale(input logic [2:0] code);
		copy_scale = (code == 3'h5) ? 2'h1 : (code == 3'h7) ? 2'h2 : 2'h0;
	endfunction

	logic [7:0]        div_cnt;
	logic              pend;
	logic [ADDR_W-1:0] pend_addr;
	logic [DATA_W-1:0] pend_data;
	logic [7:0]        hpos;
	logic [7:0]        pf_first;
	logic [7:0]        pf_second;
	logic [7:0]        pf_third;
	logic [7:0]        pf_ctrl;
	logic [7:0]        obj0_ns;
	logic [7:0]        obj1_ns;
	logic              latch_en;
	logic              dump_en;
	logic [1:0]        latch_q;
	logic [NUM_INPUTS-1:0] sync1;
	logic [NUM_INPUTS-1:0] sync2;
	logic [NUM_INPUTS-1:0] sync3;
	logic [NUM_INPUTS-1:0] pin_val;
	logic              skid_valid;
	logic [PIX_W-1:0]  skid_data;

	// colour clock: the divider waits at its last count while the buffer is full,
	// so a stalled receiver stalls the beam instead of dropping a pixel
	wire div_last = (div_cnt == 8'(COLOR_DIV - 1));
	wire in_ready = !skid_valid;
	wire tick     = div_last && in_ready;
	wire [7:0] next_div = tick ? 8'h00 : (div_last ? div_cnt : div_cnt + 8'h01);

	// writes land on the colour edge
	wire apply      = tick && pend;
	wire ap_vsync   = apply && (pend_addr == WR_VSYNC_CTRL);
	wire ap_vertical_blank_input_control  = apply && (pend_addr == WR_VERTICAL_BLANK_INPUT_CONTROL_CTRL);
	wire ap_wait    = apply && (pend_addr == WR_LINE_WAIT);
	wire ap_hreset  = apply && (pend_addr == WR_HCNT_RESET);

	wire [7:0] next_hpos = ap_hreset ? 8'h00 :
		(hpos == LINE_CLOCKS - 8'h01) ? 8'h00 : hpos + 8'h01;
	wire hblank_start = tick && (next_hpos == 8'h00);
	wire next_hblank  = next_hpos < HBLANK_CLOCKS;

	// playfield bit vector in left-half display order
	logic [PF_HALF_BITS-1:0] pf_vec;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_first
			assign pf_vec[g] = pf_first[4 + g];
		end
		for (g = 0; g < 8; g++) begin : g_mid
			assign pf_vec[4 + g]  = pf_second[7 - g];
			assign pf_vec[12 + g] = pf_third[g];
		end
	endgenerate

	wire       visible  = (hpos >= HBLANK_CLOCKS);
	wire [7:0] xpos     = hpos - HBLANK_CLOCKS;
	wire       right    = (xpos >= HALF_CLOCKS);
	wire [7:0] col      = right ? xpos - HALF_CLOCKS : xpos;
	wire [4:0] idx      = col[PF_BIT_SHIFT +: 5];
	wire       mirror   = right && pf_ctrl[REFLECT_BIT];
	wire [4:0] pf_idx   = mirror ? (PF_HALF_BITS - 5'h01 - idx) : idx;
	wire       pf_on    = visible && pf_vec[pf_idx];
	wire color_sel_type sel = !pf_ctrl[SCORE_BIT] ? SEL_PF : (right ? SEL_P1 : SEL_P0);

	logic [PIX_W-1:0] word;
	always_comb begin
		word = '0;
		word[PIX_PF] = pf_on;
		word[PIX_SEL +: 2] = sel;
		word[PIX_PRIO] = pf_ctrl[PRIO_BIT];
		word[PIX_HBL] = !visible;
		word[PIX_VBL] = o_vertical_blank_input_control;
		word[PIX_VSY] = o_vsync;
	end

	// two-entry skid buffer: output register plus one spare
	wire pop        = o_pix_valid && i_pix_ready;
	wire out_load   = pop || !o_pix_valid;
	wire next_valid = out_load ? (skid_valid || tick) : 1'b1;
	wire [PIX_W-1:0] next_out = skid_valid ? skid_data : word;
	wire next_skid  = out_load ? (skid_valid && tick) : (skid_valid || tick);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_pix_valid <= 1'b0;
			o_pix_data  <= '0;
			skid_valid  <= 1'b0;
			skid_data   <= '0;
		end else begin
			o_pix_valid <= next_valid;
			skid_valid  <= next_skid;
			if (out_load && (skid_valid || tick)) begin
				o_pix_data <= next_out;
			end
			if (tick && (skid_valid || !out_load)) begin
				skid_data <= word;
			end
		end
	end

	// write capture; a second write before the colour edge replaces the first
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pend      <= 1'b0;
			pend_addr <= '0;
			pend_data <= '0;
		end else if (i_wr_en) begin
			pend      <= 1'b1;
			pend_addr <= i_wr_addr;
			pend_data <= i_wr_data;
		end else if (tick) begin
			pend <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			div_cnt  <= '0;
			hpos     <= '0;
			o_hblank <= 1'b1;
		end else begin
			div_cnt <= next_div;
			if (tick) begin
				hpos     <= next_hpos;
				o_hblank <= next_hblank;
			end
		end
	end

	// stall and release; release wins a tie so no line is lost
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_cpu_ready <= 1'b1;
		end else if (hblank_start) begin
			o_cpu_ready <= 1'b1;
		end else if (ap_wait) begin
			o_cpu_ready <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_vsync  <= 1'b0;
			o_vertical_blank_input_control <= 1'b0;
			latch_en <= 1'b0;
			dump_en  <= 1'b0;
		end else begin
			if (ap_vsync) begin
				o_vsync <= pend_data[SYNC_BIT];
			end
			if (ap_vertical_blank_input_control) begin
				o_vertical_blank_input_control <= pend_data[VBL_BIT];
				latch_en <= pend_data[LATCH_BIT];
				dump_en  <= pend_data[DUMP_BIT];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pf_first  <= '0;
			pf_second <= '0;
			pf_third  <= '0;
			pf_ctrl   <= '0;
			obj0_ns   <= '0;
			obj1_ns   <= '0;
		end else if (apply) begin
			unique case (pend_addr)
				WR_PF_FIRST:  pf_first  <= pend_data;
				WR_PF_SECOND: pf_second <= pend_data;
				WR_PF_THIRD:  pf_third  <= pend_data;
				WR_PF_CTRL:   pf_ctrl   <= pend_data;
				WR_OBJ0_NS:   obj0_ns   <= pend_data;
				WR_OBJ1_NS:   obj1_ns   <= pend_data;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_ball_width     <= WID_W'(1);
			o_missile0_width <= WID_W'(1);
			o_missile1_width <= WID_W'(1);
			o_obj0_copies    <= COPY_W'(1);
			o_obj1_copies    <= COPY_W'(1);
			o_obj0_scale     <= '0;
			o_obj1_scale     <= '0;
		end else begin
			o_ball_width     <= size_width(pf_ctrl[SIZE_MSB:SIZE_LSB]);
			o_missile0_width <= size_width(obj0_ns[SIZE_MSB:SIZE_LSB]);
			o_missile1_width <= size_width(obj1_ns[SIZE_MSB:SIZE_LSB]);
			o_obj0_copies    <= copy_map(obj0_ns[COPY_MSB:COPY_LSB]);
			o_obj1_copies    <= copy_map(obj1_ns[COPY_MSB:COPY_LSB]);
			o_obj0_scale     <= copy_scale(obj0_ns[COPY_MSB:COPY_LSB]);
			o_obj1_scale     <= copy_scale(obj1_ns[COPY_MSB:COPY_LSB]);
		end
	end

	// pins are asynchronous; value moves once stages two and three agree
	wire [NUM_INPUTS-1:0] agree = ~(sync2 ^ sync3);
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sync1   <= '1;
			sync2   <= '1;
			sync3   <= '1;
			pin_val <= '1;
		end else begin
			sync1   <= {i_latch_pin, i_dump_pin};
			sync2   <= sync1;
			sync3   <= sync2;
			pin_val <= (agree & sync3) | (~agree & pin_val);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_dump_oe  <= '0;
			o_dump_out <= '0;
		end else begin
			o_dump_oe  <= {NUM_DUMPED{dump_en}};
			o_dump_out <= '0;
		end
	end

	// latches clear on low, return to one when disabled
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			latch_q <= 2'b11;
		end else if (!latch_en) begin
			latch_q <= 2'b11;
		end else begin
			latch_q <= latch_q & pin_val[NUM_DUMPED +: 2];
		end
	end

	// latch or direct pin on data line 7
	wire [NUM_INPUTS-1:0] in_view = {latch_en ? latch_q : pin_val[NUM_DUMPED +: 2],
		pin_val[NUM_DUMPED-1:0]};
	wire rd_hit = i_rd_en && (i_rd_addr <= RD_INPUT_LAST);
	wire [2:0] rd_idx = i_rd_addr[2:0];

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rd_data <= '0;
		end else begin
			o_rd_data         <= '0;
			o_rd_data[RD_BIT] <= rd_hit && in_view[rd_idx];
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	chk_wait_stall: assert property (ap_wait && !hblank_start |=> !o_cpu_ready)
		else $error("ready not cleared by line wait");
	chk_ready_release: assert property (hblank_start |=> o_cpu_ready && o_hblank)
		else $error("ready not set at blank start");
	chk_hcnt_reset: assert property (ap_hreset |=> hpos == 8'h00 && o_hblank)
		else $error("counter reset missed");
	chk_vsync_store: assert property (ap_vsync
		|=> o_vsync == $past(pend_data[SYNC_BIT]))
		else $error("sync bit not stored");
	chk_vertical_blank_input_control_store: assert property (ap_vertical_blank_input_control
		|=> o_vertical_blank_input_control == $past(pend_data[VBL_BIT]))
		else $error("blank bit not stored");
	chk_dump_drive: assert property (ap_vertical_blank_input_control ##1 !ap_vertical_blank_input_control
		|=> o_dump_oe == {NUM_DUMPED{$past(dump_en)}})
		else $error("dump enable wrong");
	chk_latch_release: assert property (!latch_en |=> latch_q == 2'b11)
		else $error("latches not released");
	chk_latch_hold: assert property (latch_en && !latch_q[0] ##1 latch_en |-> !latch_q[0])
		else $error("latch lost its zero");
	chk_pf_hold: assert property (tick && visible && hpos[1:0] != 2'h3 && !apply
		&& !ap_hreset |=> $stable(pf_idx))
		else $error("playfield bit changed inside four clocks");
	chk_pix_stall: assert property (o_pix_valid && !i_pix_ready
		|=> o_pix_valid && $stable(o_pix_data))
		else $error("pixel dropped under stall");
	chk_ball_width: assert property (##1 o_ball_width
		== size_width($past(pf_ctrl[SIZE_MSB:SIZE_LSB])))
		else $error("ball width wrong");

	cov_stall_release: cover property (!o_cpu_ready ##1 o_cpu_ready);
	cov_buffer_full: cover property (skid_valid && o_pix_valid && !i_pix_ready);
	cov_latch_caught: cover property (latch_en && latch_q != 2'b11);
endmodule

// ### test/cpu_writer_model.sv
`timescale 1ns/1ps
module cpu_writer_model (
	input  wire logic                              i_clk,
	input  wire logic [video_sync_pkg::DATA_W-1:0] i_rd_data,
	output logic                                   o_wr_en,
	output logic      [video_sync_pkg::ADDR_W-1:0] o_wr_addr,
	output logic      [video_sync_pkg::DATA_W-1:0] o_wr_data,
	output logic                                   o_rd_en,
	output logic      [video_sync_pkg::ADDR_W-1:0] o_rd_addr
);
	import video_sync_pkg::*;
	initial begin
		o_wr_en = 1'b0;
		o_wr_addr = '0;
		o_wr_data = '0;
		o_rd_en = 1'b0;
		o_rd_addr = '0;
	end
	// one write per 152 clocks, over two colour clocks; data lines scrambled once released
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_clk);
		o_wr_en <= 1'b1;
		o_wr_addr <= a;
		o_wr_data <= d;
		@(posedge i_clk);
		o_wr_en <= 1'b0;
		o_wr_data <= ~d;
		repeat (150) @(posedge i_clk);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(posedge i_clk);
		o_rd_en <= 1'b1;
		o_rd_addr <= a;
		@(posedge i_clk);
		o_rd_en <= 1'b0;
		o_rd_addr <= ~a;
		#1;
		v = i_rd_data;
	endtask
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
	import video_sync_pkg::*;
	logic              clk;
	logic              rst;
	logic              wr_en;
	logic              rd_en;
	logic              pix_ready;
	logic              pix_valid;
	logic              cpu_ready;
	logic              vsync;
	logic              vertical_blank_input_control;
	logic              hblank;
	logic [ADDR_W-1:0] wr_addr;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] wr_data;
	logic [DATA_W-1:0] rd_data;
	logic [DATA_W-1:0] v;
	logic [3:0]        dump_pin;
	logic [3:0]        dump_out;
	logic [3:0]        dump_oe;
	logic [1:0]        latch_pin;
	logic [PIX_W-1:0]  pix_data;
	logic [PIX_W-1:0]  held;
	logic [WID_W-1:0]  bw;
	logic [WID_W-1:0]  m0w;
	logic [WID_W-1:0]  m1w;
	logic [COPY_W-1:0] c0;
	logic [COPY_W-1:0] c1;
	logic [1:0]        s0;
	logic [1:0]        s1;
	int seed = 31252;
	int num_errors = 0;
	int n_checks = 0;
	int pf0, pf1, pf2, ctl, cnt, lines, i, k;
	bit arm, active, hold;

	video_sync_playfield_control video_sync_playfield_control_inst (
		.i_clk(clk), .i_sys_rst(rst), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
		.i_wr_data(wr_data), .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
		.o_cpu_ready(cpu_ready), .i_dump_pin(dump_pin), .o_dump_out(dump_out),
		.o_dump_oe(dump_oe), .i_latch_pin(latch_pin), .o_vsync(vsync), .o_vertical_blank_input_control(vertical_blank_input_control),
		.o_hblank(hblank), .o_pix_valid(pix_valid), .i_pix_ready(pix_ready),
		.o_pix_data(pix_data), .o_ball_width(bw), .o_missile0_width(m0w),
		.o_missile1_width(m1w), .o_obj0_copies(c0), .o_obj1_copies(c1),
		.o_obj0_scale(s0), .o_obj1_scale(s1));
	cpu_writer_model cpu_writer_model_inst (
		.i_clk(clk), .i_rd_data(rd_data), .o_wr_en(wr_en), .o_wr_addr(wr_addr),
		.o_wr_data(wr_data), .o_rd_en(rd_en), .o_rd_addr(rd_addr));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic gave_up();
		num_errors++;
		$display("[ERR] %0t wait ran out", $time);
		end_sim();
	endtask
	// start a test inside the visible part so no line start ties with it
	task automatic wait_vis();
		for (i = 0; i < 20000 && hblank !== 1'b0; i++)
			@(posedge clk);
		if (hblank !== 1'b0)
			gave_up();
	endtask

	function automatic logic exp_pf(input int x);
		int b;
		b = (x % 80) / 4;
		if (x >= 80 && ctl[0])
			b = 19 - b;
		if (b < 4)
			return pf0[4 + b];
		if (b < 12)
			return pf1[11 - b];
		return pf2[b - 12];
	endfunction
	function automatic logic [8:0] exp_copy(input int p);
		case (p)
			1: return 9'h005;
			2: return 9'h011;
			3: return 9'h015;
			4: return 9'h101;
			6: return 9'h111;
			default: return 9'h001;
		endcase
	endfunction

	// receiver stalls at random, or for long stretches on demand
	always @(posedge clk)
		pix_ready <= hold ? 1'b0 : (($random(seed) & 3) != 0);

	// behavioural playfield model, compared at every accepted word while active is set
	always @(posedge clk) begin
		if (pix_valid && pix_ready) begin
			if (pix_data[PIX_HBL]) begin
				if (active && cnt != 0) begin
					check(cnt, 160);
					lines++;
				end
				cnt = 0;
				if (arm)
					active = 1;
			end else if (active) begin
				check(pix_data[PIX_PF], exp_pf(cnt));
				check(pix_data[PIX_PRIO], ctl[2]);
				check(pix_data[PIX_VSY -: 2], 2'b00);
				if (pix_data[PIX_PF])
					check(pix_data[2:1], ctl[1] ? (cnt < 80 ? 1 : 2) : 0);
				cnt++;
			end
		end
	end

	task automatic pf_line(input int c);
		bit stalled;
		stalled = 1'b0;
		pf0 = $random(seed) & 8'hff;
		pf1 = $random(seed) & 8'hff;
		pf2 = $random(seed) & 8'hff;
		ctl = c;
		cpu_writer_model_inst.wr(WR_PF_FIRST, pf0[7:0]);
		cpu_writer_model_inst.wr(WR_PF_SECOND, pf1[7:0]);
		cpu_writer_model_inst.wr(WR_PF_THIRD, pf2[7:0]);
		cpu_writer_model_inst.wr(WR_PF_CTRL, ctl[7:0]);
		lines = 0;
		arm = 1;
		for (i = 0; i < 30000 && lines < 1; i++) begin
			@(posedge clk);
			if (active && cnt == 40 && !stalled) begin
				stalled = 1'b1;
				hold = 1;
				repeat (3) @(posedge clk);
				// capture only a word that is really waiting under the stall
				for (k = 0; k < 300 && pix_valid !== 1'b1; k++)
					@(posedge clk);
				#1 held = pix_data;
				repeat (600) @(posedge clk);
				check({pix_valid, pix_data}, {1'b1, held});
				hold = 0;
			end
		end
		if (lines < 1)
			gave_up();
		#1 arm = 0;
		active = 0;
	endtask

	initial begin
		rst = 1'b1;
		dump_pin = 4'hf;
		latch_pin = 2'b11;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 check({cpu_ready, vsync, vertical_blank_input_control, bw, c0},
			{1'b1, 1'b0, 1'b0, 4'h1, 9'h001});
		cpu_writer_model_inst.wr(WR_VSYNC_CTRL, 8'h02 | ($random(seed) & 8'hfd));
		check(vsync, 1);
		cpu_writer_model_inst.wr(WR_VSYNC_CTRL, $random(seed) & 8'hfd);
		check(vsync, 0);
		cpu_writer_model_inst.wr(WR_VERTICAL_BLANK_INPUT_CONTROL_CTRL, 8'hc2);
		check({vertical_blank_input_control, dump_oe, dump_out}, {1'b1, 4'hf, 4'h0});
		cpu_writer_model_inst.rd(6'h04, v);
		check(v, 8'h80);
		latch_pin <= 2'b10;
		repeat (8) @(posedge clk);
		latch_pin <= 2'b11;
		repeat (8) @(posedge clk);
		cpu_writer_model_inst.rd(6'h04, v);
		check(v, 8'h00);
		cpu_writer_model_inst.rd(6'h05, v);
		check(v, 8'h80);
		cpu_writer_model_inst.wr(WR_VERTICAL_BLANK_INPUT_CONTROL_CTRL, 8'h00);
		check({vertical_blank_input_control, dump_oe}, 0);
		cpu_writer_model_inst.rd(6'h04, v);
		check(v, 8'h80);
		latch_pin <= 2'b01;
		repeat (8) @(posedge clk);
		cpu_writer_model_inst.rd(6'h05, v);
		check(v, 8'h00);
		latch_pin <= 2'b11;
		for (k = 0; k < 4; k++) begin
			dump_pin <= $random(seed);
			repeat (8) @(posedge clk);
			cpu_writer_model_inst.rd(k[5:0], v);
			check(v, {dump_pin[k], 7'h0});
		end
		cpu_writer_model_inst.rd(6'h06, v);
		check(v, 0);
		for (k = 0; k < 4; k++) begin
			cpu_writer_model_inst.wr(WR_PF_CTRL, k[7:0] << 4);
			cpu_writer_model_inst.wr(WR_OBJ0_NS, (k[7:0] << 4) | k[7:0]);
			cpu_writer_model_inst.wr(WR_OBJ1_NS, ((3 - k[7:0]) << 4) | (k[7:0] + 4));
			check({bw, m0w, m1w}, {4'h1 << k, 4'h1 << k, 4'h8 >> k});
			check({c0, s0}, {exp_copy(k), 2'd0});
			check({c1, s1}, {exp_copy(k + 4), k == 1 ? 2'd1 : k == 3 ? 2'd2 : 2'd0});
		end
		wait_vis();
		fork
			cpu_writer_model_inst.wr(WR_LINE_WAIT, $random(seed));
			begin
				for (i = 0; i < 150 && cpu_ready !== 1'b0; i++)
					@(posedge clk);
				check(cpu_ready, 0);
				for (i = 0; i < 20000 && cpu_ready !== 1'b1; i++)
					@(posedge clk);
				#1 check({cpu_ready, hblank}, 2'b11);
			end
		join
		wait_vis();
		repeat (700) @(posedge clk);
		fork
			cpu_writer_model_inst.wr(WR_HCNT_RESET, $random(seed));
			begin
				for (i = 0; i < 150 && hblank !== 1'b1; i++)
					@(posedge clk);
				check(hblank, 1);
			end
		join
		pf_line(8'h00);
		pf_line(8'h07);
		end_sim();
	end
endmodule
